// File: logic/wscr_pkg.sv
package wscr_pkg;

  // ----------------------------------------------------------------
  // Register addresses (7-bit register address field)
  // ----------------------------------------------------------------
  localparam logic [6:0] WSCR_ADDR_BUS_MODE = 7'h04;
  localparam logic [6:0] WSCR_ADDR_INT_WAKE = 7'h06;
  localparam logic [6:0] WSCR_ADDR_EXT_WAKE = 7'h07;
  localparam logic [6:0] WSCR_ADDR_PULL = 7'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int WSCR_BIT_TIMER2_WK = 7;
  localparam int WSCR_BIT_TIMER1_WK = 6;
  localparam int WSCR_BIT_STOP_WD_HI = 2;
  localparam int WSCR_BIT_INT_GLOBAL = 7;
  localparam int WSCR_BIT_MEAS = 5;
  localparam int WSCR_BIT_WAKE_INPUT_THREE_ENABLE = 2;
  localparam int WSCR_BIT_WAKE_INPUT_TWO_ENABLE = 1;
  localparam int WSCR_BIT_WAKE_INPUT_ONE_ENABLE = 0;
  localparam int WSCR_NUM_WAKE_INPUTS = 3;

  // ----------------------------------------------------------------
  // Writable masks, reset and forced values
  // ----------------------------------------------------------------
  localparam logic [7:0] WSCR_MASK_INT_WAKE = 8'hC4;
  localparam logic [7:0] WSCR_MASK_EXT_WAKE = 8'hA7;
  localparam logic [7:0] WSCR_MASK_PULL = 8'h3F;
  localparam logic [7:0] WSCR_MASK_BUS_MODE = 8'h07;
  localparam logic [7:0] WSCR_RST_INT_WAKE = 8'h00;
  localparam logic [7:0] WSCR_RST_EXT_WAKE = 8'h07;
  localparam logic [7:0] WSCR_RST_PULL = 8'h00;
  localparam logic [7:0] WSCR_RST_BUS_MODE = 8'h00;
  // Restart clears bits 6, 4 and 3 of the external wake register only
  localparam logic [7:0] WSCR_RESTART_KEEP_EXT = 8'hA7;
  // Fail-safe: bus register keeps bits 7:5, ext register keeps 7 and 5
  localparam logic [7:0] WSCR_FS_KEEP_BUS = 8'hE0;
  localparam logic [7:0] WSCR_FS_SET_BUS = 8'h01;
  localparam logic [7:0] WSCR_FS_KEEP_EXT = 8'hA0;
  localparam logic [7:0] WSCR_FS_SET_EXT = 8'h07;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WSCR_PULL_NONE = 2'h0;
  localparam logic [1:0] WSCR_PULL_DOWN = 2'h1;
  localparam logic [1:0] WSCR_PULL_UP = 2'h2;
  localparam logic [1:0] WSCR_PULL_AUTO = 2'h3;
  localparam logic [2:0] WSCR_CAN_WAKE_PLAIN = 3'h1;
  localparam logic [2:0] WSCR_CAN_WAKE_SEL = 3'h5;

endpackage

// File: logic/wscr_regs.sv
`timescale 1ns/1ns
// Operation
// R1: Bit 7 enables second timer wake
// R2: Bit 6 enables first timer wake
// R3: Bit 2 stop watchdog off; device may update
// R4: Reserved bits always read zero
// R5: Bit 7 widens interrupt to all status
// R6: Measurement bit masks wake inputs one, two
// R7: Measurement runs in Normal Mode only
// R8: Bits 2..0 enable wake inputs three..one
// R9: Fail-safe forces bus and wake patterns
// R10: Host enables CAN wake via mode field
// R11: Pull field: none, down, up, auto
// R12: Pull fields at 5:4, 3:2, 1:0
// R13: Reset loads 07; restart clears some bits
// R14: Mode 001/101 means CAN wake capable
// R15: Reserved bit writes are discarded
module wscr_regs
  import wscr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic restartEntry,
  input wire logic failSafeEntry,
  input wire logic normalMode,
  input wire logic regWrite,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic stopWdSet,
  input wire logic stopWdClear,
  input wire logic [2:0] statusWake,
  input wire logic statusOther,
  output logic [7:0] regReadData,
  output logic secondTimerWake,
  output logic firstTimerWake,
  output logic stopWatchdogOff,
  output logic [2:0] wakeInputEnable,
  output logic measurementActive,
  output logic canWakeCapable,
  output logic selectiveWake,
  output logic interruptRequest,
  output logic [1:0] wakeInputOnePull,
  output logic [1:0] wakeInputTwoPull,
  output logic [1:0] wakeInputThreePull
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] intWake_q, intWake_d;
  logic [7:0] extWake_q, extWake_d;
  logic [7:0] pull_q, pull_d;
  logic [7:0] busMode_q, busMode_d;
  logic [7:0] readMux;

  // Address decode
  wire hitInt = regWrite && (regAddr == WSCR_ADDR_INT_WAKE);
  wire hitExt = regWrite && (regAddr == WSCR_ADDR_EXT_WAKE);
  wire hitPull = regWrite && (regAddr == WSCR_ADDR_PULL);
  wire hitBus = regWrite && (regAddr == WSCR_ADDR_BUS_MODE);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Host write merges only the writable bits; reserved stay zero
  wire [7:0] intWr = (intWake_q & ~WSCR_MASK_INT_WAKE) |
                     (regWriteData & WSCR_MASK_INT_WAKE); // R15
  wire [7:0] extWr = (extWake_q & ~WSCR_MASK_EXT_WAKE) |
                     (regWriteData & WSCR_MASK_EXT_WAKE); // R15
  wire [7:0] pullWr = (pull_q & ~WSCR_MASK_PULL) | (regWriteData & WSCR_MASK_PULL); // R15
  wire [7:0] busWr = (busMode_q & ~WSCR_MASK_BUS_MODE) |
                     (regWriteData & WSCR_MASK_BUS_MODE); // R15

  // Device update of stop watchdog bit; set beats clear
  wire [7:0] intHw = {intWr[7:3], (intWr[WSCR_BIT_STOP_WD_HI] & ~stopWdClear) | stopWdSet,
                      intWr[1:0]}; // R3

  // Priority: soft reset, fail-safe, restart, host write
  always_comb begin
    intWake_d = hitInt ? intHw : {intWake_q[7:3],
                (intWake_q[WSCR_BIT_STOP_WD_HI] & ~stopWdClear) | stopWdSet,
                intWake_q[1:0]};
    extWake_d = hitExt ? extWr : extWake_q;
    pull_d = hitPull ? pullWr : pull_q;
    busMode_d = hitBus ? busWr : busMode_q;
    if (restartEntry) begin
      extWake_d = extWake_q & WSCR_RESTART_KEEP_EXT; // R13
    end
    if (failSafeEntry) begin
      busMode_d = (busMode_q & WSCR_FS_KEEP_BUS) | WSCR_FS_SET_BUS; // R9
      extWake_d = (extWake_q & WSCR_FS_KEEP_EXT) | WSCR_FS_SET_EXT; // R9
    end
    if (softReset) begin
      intWake_d = WSCR_RST_INT_WAKE;
      extWake_d = WSCR_RST_EXT_WAKE; // R13
      pull_d = WSCR_RST_PULL;
      busMode_d = WSCR_RST_BUS_MODE;
    end
  end

  // Internal wake register; the mask keeps reserved bits at zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      intWake_q <= WSCR_RST_INT_WAKE;
    end else begin
      intWake_q <= intWake_d & WSCR_MASK_INT_WAKE; // R4
    end
  end

  // External wake register; reset leaves all three wake inputs armed
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      extWake_q <= WSCR_RST_EXT_WAKE; // R13
    end else begin
      extWake_q <= extWake_d & WSCR_MASK_EXT_WAKE; // R4
    end
  end

  // Pull register; fields only, reserved top bits never stored
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pull_q <= WSCR_RST_PULL;
    end else begin
      pull_q <= pull_d & WSCR_MASK_PULL; // R4
    end
  end

  // Bus mode register; its mode field feeds the CAN wake flags
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busMode_q <= WSCR_RST_BUS_MODE;
    end else begin
      busMode_q <= busMode_d & WSCR_MASK_BUS_MODE; // R4
    end
  end

  // ----------------------------------------------------------------
  // Read path and decoded controls
  // ----------------------------------------------------------------
  // Unmapped addresses and reserved bits read zero
  assign readMux = (regAddr == WSCR_ADDR_INT_WAKE) ? (intWake_q & WSCR_MASK_INT_WAKE) :
                   (regAddr == WSCR_ADDR_EXT_WAKE) ? (extWake_q & WSCR_MASK_EXT_WAKE) :
                   (regAddr == WSCR_ADDR_PULL) ? (pull_q & WSCR_MASK_PULL) :
                   (regAddr == WSCR_ADDR_BUS_MODE) ? (busMode_q & WSCR_MASK_BUS_MODE) :
                   8'h00; // R4

  // Measurement overrides enables of inputs one and two
  wire measSel = extWake_d[WSCR_BIT_MEAS];
  wire [2:0] enNext = {extWake_d[WSCR_BIT_WAKE_INPUT_THREE_ENABLE],
                       extWake_d[WSCR_BIT_WAKE_INPUT_TWO_ENABLE] & ~measSel,
                       extWake_d[WSCR_BIT_WAKE_INPUT_ONE_ENABLE] & ~measSel}; // R6 R8

  // CAN wake capable for plain or selective wake modes
  wire [2:0] canMode = busMode_d[2:0];
  wire canWakeNext = (canMode == WSCR_CAN_WAKE_PLAIN) || (canMode == WSCR_CAN_WAKE_SEL); // R14

  // Global scope lets any status bit raise the interrupt
  wire intNext = (|statusWake) || (extWake_q[WSCR_BIT_INT_GLOBAL] && statusOther); // R5

  // Read data lags the address by one edge; the host samples after it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regReadData <= 8'h00;
    end else begin
      regReadData <= readMux; // R4
    end
  end

  // Controls come from next values, so they move with the write edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      secondTimerWake <= 1'b0;
      firstTimerWake <= 1'b0;
      stopWatchdogOff <= 1'b0;
    end else begin
      secondTimerWake <= intWake_d[WSCR_BIT_TIMER2_WK]; // R1
      firstTimerWake <= intWake_d[WSCR_BIT_TIMER1_WK]; // R2
      stopWatchdogOff <= intWake_d[WSCR_BIT_STOP_WD_HI]; // R3
    end
  end

  // Wake enables already carry the measurement override
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wakeInputEnable <= WSCR_RST_EXT_WAKE[2:0];
      measurementActive <= 1'b0;
    end else begin
      wakeInputEnable <= enNext; // R8
      measurementActive <= measSel && normalMode; // R7
    end
  end

  // CAN wake flags; selective wake only with a wake capable mode
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      canWakeCapable <= 1'b0;
      selectiveWake <= 1'b0;
    end else begin
      canWakeCapable <= canWakeNext; // R14
      selectiveWake <= canWakeNext && canMode[2]; // R14
    end
  end

  // Interrupt is a level; status sources must hold until serviced
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interruptRequest <= 1'b0;
    end else begin
      interruptRequest <= intNext; // R5
    end
  end

  // Pull selections are passed on undecoded to the pad logic
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wakeInputOnePull <= WSCR_PULL_NONE;
      wakeInputTwoPull <= WSCR_PULL_NONE;
      wakeInputThreePull <= WSCR_PULL_NONE;
    end else begin
      wakeInputOnePull <= pull_d[1:0]; // R11 R12
      wakeInputTwoPull <= pull_d[3:2]; // R12
      wakeInputThreePull <= pull_d[5:4]; // R12
    end
  end

endmodule

// File: sim/wscr_host_model.sv
`timescale 1ns/1ns
// ---------------------------------
// Host microcontroller register port
// ---------------------------------
module wscr_host_model (
  input wire logic clock,
  output logic regWrite,
  output logic [6:0] regAddr,
  output logic [7:0] regWriteData
);
  initial begin
    regWrite = 1'b0;
    regAddr = 7'h00;
    regWriteData = 8'h00;
  end
  // One-cycle strobe off the falling edge; data flipped after so none lingers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    @(negedge clock);
    regWrite = 1'b0;
    regWriteData = ~d;
  endtask
  // Read data is registered, so it is ready one edge after the address
  task automatic rd(input logic [6:0] a);
    @(negedge clock);
    regAddr = a;
    @(negedge clock);
  endtask
endmodule

// File: sim/wscr_regs_properties.sv
`timescale 1ns/1ns
// ---------------------------
// Register bank checks
// ---------------------------
module wscr_regs_properties
  import wscr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic restartEntry,
  input wire logic failSafeEntry,
  input wire logic regWrite,
  input wire logic stopWdSet,
  input wire logic secondTimerWake,
  input wire logic firstTimerWake,
  input wire logic stopWatchdogOff,
  input wire logic canWakeCapable,
  input wire logic selectiveWake,
  input wire logic interruptRequest,
  input wire logic [2:0] statusWake,
  input wire logic [2:0] wakeInputEnable,
  input wire logic [6:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic [1:0] wakeInputThreePull
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Host writes only, since reset, restart and fail-safe win over them
  wire quiet = regWrite & ~softReset & ~restartEntry & ~failSafeEntry;
  a_timer_two_wake: assert property (quiet && regAddr == 7'h06
    |=> secondTimerWake == $past(regWriteData[7])) else $error("timer two wake");
  a_timer_one_wake: assert property (quiet && regAddr == 7'h06
    |=> firstTimerWake == $past(regWriteData[6])) else $error("timer one wake");
  a_stop_wd_set: assert property (stopWdSet && !softReset
    |=> stopWatchdogOff) else $error("watchdog off not set");
  a_int_reserved_zero: assert property ($past(regAddr) == 7'h06
    |-> (regReadData & 8'h3B) == 8'h00) else $error("reserved bits read");
  a_meas_masks_wake: assert property (quiet && regAddr == 7'h07 && regWriteData[5]
    |=> wakeInputEnable[1:0] == 2'h0) else $error("measurement mask");
  a_wake_three_en: assert property (quiet && regAddr == 7'h07
    |=> wakeInputEnable[2] == $past(regWriteData[2])) else $error("wake three enable");
  a_fail_safe_wake: assert property (failSafeEntry && !softReset
    |=> wakeInputEnable[2] && canWakeCapable && !selectiveWake) else $error("fail-safe");
  a_soft_reset_load: assert property (softReset
    |=> wakeInputEnable == 3'h7 && !secondTimerWake) else $error("soft reset");
  a_pull_three_field: assert property (quiet && regAddr == 7'h08
    |=> wakeInputThreePull == $past(regWriteData[5:4])) else $error("pull field");
  a_wake_raises_int: assert property (|statusWake
    |=> interruptRequest) else $error("wake interrupt missing");
endmodule
bind wscr_regs wscr_regs_properties chk (.clock, .rst_n, .softReset, .restartEntry,
  .failSafeEntry, .regWrite, .stopWdSet, .secondTimerWake, .firstTimerWake, .stopWatchdogOff,
  .canWakeCapable, .selectiveWake, .interruptRequest, .statusWake, .wakeInputEnable,
  .regAddr, .regWriteData, .regReadData, .wakeInputThreePull);

// File: sim/wscr_regs_tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t got %0h expected %0h", $time, a, e); end end
// ---------------------------
// Register bank testbench
// ---------------------------
module wscr_regs_tb;
  logic clock = 1'b0, rst_n = 1'b0, softReset = 1'b0, restartEntry = 1'b0;
  logic failSafeEntry = 1'b0, normalMode = 1'b0, stopWdSet = 1'b0, stopWdClear = 1'b0;
  logic statusOther = 1'b0, regWrite, secondTimerWake, firstTimerWake, stopWatchdogOff;
  logic measurementActive, canWakeCapable, selectiveWake, interruptRequest;
  logic [2:0] statusWake = 3'h0, wakeInputEnable;
  logic [6:0] regAddr;
  logic [7:0] regWriteData, regReadData;
  logic [1:0] wakeInputOnePull, wakeInputTwoPull, wakeInputThreePull;
  int miscompares = 0, checksDone = 0;
  always #25 clock = ~clock;
  wscr_host_model host (.clock, .regWrite, .regAddr, .regWriteData);
  wscr_regs dut (.clock, .rst_n, .softReset, .restartEntry, .failSafeEntry, .normalMode,
    .regWrite, .regAddr, .regWriteData, .stopWdSet, .stopWdClear, .statusWake, .statusOther,
    .regReadData, .secondTimerWake, .firstTimerWake, .stopWatchdogOff, .wakeInputEnable,
    .measurementActive, .canWakeCapable, .selectiveWake, .interruptRequest,
    .wakeInputOnePull, .wakeInputTwoPull, .wakeInputThreePull);
  task automatic end_of_test();
    if (miscompares == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    host.rd(a);
    `CHK(regReadData, e)
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask
  // Guard against a hung run
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    `CHK(wakeInputEnable, 3'h7)
    rc(7'h07, 8'h07);
    rc(7'h08, 8'h00);
    host.wr(7'h06, 8'hFF);
    `CHK({secondTimerWake, firstTimerWake, stopWatchdogOff}, 3'h7)
    rc(7'h06, 8'hC4);
    pulse(stopWdClear);
    `CHK(stopWatchdogOff, 1'b0)
    pulse(stopWdSet);
    `CHK(stopWatchdogOff, 1'b1)
    host.wr(7'h06, 8'h40);
    `CHK({secondTimerWake, firstTimerWake, stopWatchdogOff}, 3'h2)
    @(negedge clock);
    stopWdSet = 1'b1;
    stopWdClear = 1'b1;
    @(negedge clock);
    stopWdSet = 1'b0;
    stopWdClear = 1'b0;
    `CHK(stopWatchdogOff, 1'b1)
    for (int i = 0; i < 4; i++) begin
      host.wr(7'h08, {2'h3, 2'(i), 2'(3 - i), 2'(i)});
      `CHK({wakeInputThreePull, wakeInputTwoPull, wakeInputOnePull}, {2'(i), 2'(3 - i), 2'(i)})
      rc(7'h08, {2'h0, 2'(i), 2'(3 - i), 2'(i)});
    end
    normalMode = 1'b1;
    host.wr(7'h07, 8'hFF);
    `CHK({wakeInputEnable, measurementActive}, 4'h9)
    normalMode = 1'b0;
    @(negedge clock);
    `CHK(measurementActive, 1'b0)
    normalMode = 1'b1;
    rc(7'h07, 8'hA7);
    statusOther = 1'b1;
    @(negedge clock);
    `CHK(interruptRequest, 1'b1)
    host.wr(7'h07, 8'h03);
    `CHK({wakeInputEnable, measurementActive}, 4'h6)
    @(negedge clock);
    `CHK(interruptRequest, 1'b0)
    statusOther = 1'b0;
    statusWake = 3'h4;
    @(negedge clock);
    `CHK(interruptRequest, 1'b1)
    statusWake = 3'h0;
    host.wr(7'h04, 8'h05);
    `CHK({canWakeCapable, selectiveWake}, 2'h3)
    host.wr(7'h04, 8'h02);
    `CHK({canWakeCapable, selectiveWake}, 2'h0)
    host.wr(7'h07, 8'hA0);
    pulse(restartEntry);
    rc(7'h07, 8'hA0);
    pulse(failSafeEntry);
    rc(7'h04, 8'h01);
    rc(7'h07, 8'hA7);
    pulse(softReset);
    rc(7'h07, 8'h07);
    rc(7'h06, 8'h00);
    host.wr(7'h10, 8'hFF);
    rc(7'h10, 8'h00);
    end_of_test();
  end
endmodule
